// ===== src/fpp_port.sv
// flash program port: link register file, flash pin control and config loader
`timescale 1ns/100ps
`default_nettype none
module fpp_port (
  input wire logic ref_clk, // 25 MHz system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic [5:0] link_addr, // register address bits 7:2
  input wire logic [7:0] link_d_in, // link data lines, input side
  output logic [7:0] link_d_out, // link data lines, output side
  output logic link_d_oe_n, // link data drive enable, active low
  input wire logic link_rd_n, // read strobe, active low
  input wire logic link_wr_n, // write strobe, active low
  output logic [18:0] flash_addr, // flash address
  input wire logic [7:0] flash_dq_in, // flash data lines, input side
  output logic [7:0] flash_dq_out, // flash data lines, output side
  output logic flash_dq_oe_n, // flash data drive enable, active low
  output logic flash_ce_n, // flash chip enable
  output logic flash_oe_n, // flash output enable
  output logic flash_we_n, // flash write enable
  input wire logic fpga_done, // configuration done level
  input wire logic fpga_init_n, // fpga init, active low
  output logic fpga_prog_n, // start configuration, active low
  output logic [7:0] cfg_data, // configuration byte to the fpgas
  output logic cfg_cclk // configuration clock to the fpgas
);
  localparam int unsigned SYNC_W = 26;

  logic [SYNC_W-1:0] sync_q;
  logic rd_n_f;
  logic wr_n_f;
  logic [5:0] addr_f;
  logic [7:0] din_f;
  logic [7:0] dq_f;
  logic done_f;
  logic init_n_f;
  logic rd_prev_q;
  logic wr_prev_q;
  logic rd_evt;
  logic wr_evt;
  logic soft_rst_q;
  logic host_ok;
  logic max_addr;
  logic [7:0] status;
  logic [7:0] rd_val;
  fpp_pkg::fpp_cfg_state_t cfg_state_q;
  logic [4:0] cyc_q;
  logic [18:0] cfg_cnt_q;
  logic [18:0] cfg_cnt_d;

  function automatic logic hit(input logic [5:0] a, input logic [7:0] ofs);
    return a == ofs[7:fpp_pkg::OFS_LSB];
  endfunction

  // all pins share one synchroniser; strobes idle high
  fpp_sync #(
    .W(SYNC_W),
    .INIT(26'h3000000)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .d({link_rd_n, link_wr_n, link_addr, link_d_in, flash_dq_in, fpga_done, fpga_init_n}),
    .q(sync_q)
  );
  assign {rd_n_f, wr_n_f, addr_f, din_f, dq_f, done_f, init_n_f} = sync_q;

  // strobe edges; address and data ride through the same delay as the strobe
  assign rd_evt = rd_prev_q & ~rd_n_f;
  assign wr_evt = wr_prev_q & ~wr_n_f;
  // while the loader runs it owns the flash pins
  assign host_ok = (cfg_state_q == fpp_pkg::CFG_IDLE) && !soft_rst_q;
  assign max_addr = cfg_cnt_q == fpp_pkg::CFG_MAX_ADDR; // RULE12

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end
    else if (clk_en)
    begin
      rd_prev_q <= rd_n_f;
      wr_prev_q <= wr_n_f;
    end
  end

  // data value is ignored; any write restarts
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      soft_rst_q <= 1'b0;
    else if (clk_en)
      soft_rst_q <= wr_evt && hit(addr_f, fpp_pkg::OFS_RESET); // RULE10
  end

  // flash address register, shared by host writes and the loader
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      flash_addr <= fpp_pkg::ADDR_RESET;
    else if (clk_en)
    begin
      if (soft_rst_q)
        flash_addr <= fpp_pkg::ADDR_RESET;
      else if (cfg_state_q != fpp_pkg::CFG_IDLE)
        flash_addr <= cfg_cnt_q;
      else if (wr_evt)
      begin
        if (hit(addr_f, fpp_pkg::OFS_ADDR_LOW))
          flash_addr[fpp_pkg::ADDR_LOW_LSB +: 8] <= din_f; // RULE7
        else if (hit(addr_f, fpp_pkg::OFS_ADDR_MID))
          flash_addr[fpp_pkg::ADDR_MID_LSB +: 8] <= din_f; // RULE8
        else if (hit(addr_f, fpp_pkg::OFS_ADDR_HIGH))
          flash_addr[fpp_pkg::ADDR_HIGH_LSB +: fpp_pkg::ADDR_HIGH_W] <=
            din_f[fpp_pkg::ADDR_HIGH_W-1:0]; // RULE9
        else if (hit(addr_f, fpp_pkg::OFS_CMD))
        begin
          if (din_f == fpp_pkg::CMD_UNLOCK_LO)
            flash_addr <= fpp_pkg::UNLOCK_ADDR_LO; // RULE1
          else if (din_f == fpp_pkg::CMD_UNLOCK_HI)
            flash_addr <= fpp_pkg::UNLOCK_ADDR_HI; // RULE2
        end
      end
    end
  end

  // strobes and data drive direction move together so the data lines
  // never fight the flash while its outputs are on
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      if (soft_rst_q)
      begin
        flash_ce_n <= 1'b1;
        flash_oe_n <= 1'b1;
        flash_we_n <= 1'b1;
        flash_dq_oe_n <= 1'b1;
      end
      else if (cfg_state_q != fpp_pkg::CFG_IDLE)
      begin
        flash_ce_n <= !(cfg_state_q == fpp_pkg::CFG_READ || cfg_state_q == fpp_pkg::CFG_CLOCK);
        flash_oe_n <= !(cfg_state_q == fpp_pkg::CFG_READ || cfg_state_q == fpp_pkg::CFG_CLOCK);
        flash_we_n <= 1'b1;
        flash_dq_oe_n <= 1'b1;
      end
      else if (wr_evt && hit(addr_f, fpp_pkg::OFS_CMD))
      begin
        case (din_f)
          fpp_pkg::CMD_READ:
          begin
            flash_ce_n <= 1'b0; // RULE3
            flash_oe_n <= 1'b0;
            flash_we_n <= 1'b1;
            flash_dq_oe_n <= 1'b1;
          end
          fpp_pkg::CMD_WRITE:
          begin
            flash_ce_n <= 1'b0; // RULE4
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b0;
            flash_dq_oe_n <= 1'b0;
          end
          fpp_pkg::CMD_STANDBY:
          begin
            flash_ce_n <= 1'b1; // RULE5
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_dq_oe_n <= 1'b0;
          end
          default:
          begin
            // other codes hold the present state
            flash_ce_n <= flash_ce_n; // RULE18
            flash_oe_n <= flash_oe_n;
            flash_we_n <= flash_we_n;
            flash_dq_oe_n <= flash_dq_oe_n;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      flash_dq_out <= fpp_pkg::BYTE_ZERO;
    else if (clk_en && host_ok && wr_evt && hit(addr_f, fpp_pkg::OFS_DATA))
      flash_dq_out <= din_f; // RULE6
  end

  assign status = {flash_we_n, flash_oe_n, flash_ce_n, max_addr,
                   cfg_state_q != fpp_pkg::CFG_IDLE, fpga_prog_n, init_n_f, done_f}; // RULE11

  // write-only and unmapped addresses read as zero
  always_comb
  begin
    if (hit(addr_f, fpp_pkg::OFS_STATUS))
      rd_val = status;
    else if (hit(addr_f, fpp_pkg::OFS_DATA))
      rd_val = dq_f; // RULE6
    else if (hit(addr_f, fpp_pkg::OFS_ADDR_LOW))
      rd_val = flash_addr[fpp_pkg::ADDR_LOW_LSB +: 8]; // RULE7
    else if (hit(addr_f, fpp_pkg::OFS_ADDR_HIGH))
      rd_val = {5'h00, flash_addr[fpp_pkg::ADDR_HIGH_LSB +: fpp_pkg::ADDR_HIGH_W]}; // RULE9
    else
      rd_val = fpp_pkg::BYTE_ZERO;
  end

  // answer is caught at the strobe edge and held until the strobe ends
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_d_out <= fpp_pkg::BYTE_ZERO;
      link_d_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      link_d_oe_n <= rd_n_f;
      if (rd_evt)
        link_d_out <= rd_val;
    end
  end

  assign cfg_cnt_d = cfg_cnt_q + 19'h00001;

  // loader: pulse prog_n, wait for init_n, then clock bytes out until done, init_n low
  // or the top of the image; a stuck-low init_n parks it in the wait state
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_state_q <= fpp_pkg::CFG_PROG;
      cyc_q <= fpp_pkg::CYC_ZERO;
      cfg_cnt_q <= fpp_pkg::ADDR_RESET;
      fpga_prog_n <= 1'b0;
      cfg_data <= fpp_pkg::BYTE_ZERO;
      cfg_cclk <= 1'b0;
    end
    else if (clk_en)
    begin
      if (soft_rst_q)
      begin
        cfg_state_q <= fpp_pkg::CFG_PROG; // RULE10
        cyc_q <= fpp_pkg::CYC_ZERO;
        cfg_cnt_q <= fpp_pkg::ADDR_RESET;
        fpga_prog_n <= 1'b0;
        cfg_cclk <= 1'b0;
      end
      else
      begin
        case (cfg_state_q)
          fpp_pkg::CFG_PROG:
          begin
            cyc_q <= cyc_q + fpp_pkg::CYC_ONE;
            if (cyc_q == fpp_pkg::PROG_PULSE_CYC - fpp_pkg::CYC_ONE)
            begin
              fpga_prog_n <= 1'b1;
              cfg_state_q <= fpp_pkg::CFG_WAIT_INIT;
            end
          end
          fpp_pkg::CFG_WAIT_INIT:
          begin
            cyc_q <= fpp_pkg::CYC_ZERO;
            if (init_n_f)
              cfg_state_q <= fpp_pkg::CFG_READ;
          end
          fpp_pkg::CFG_READ:
          begin
            cyc_q <= cyc_q + fpp_pkg::CYC_ONE;
            if (cyc_q == fpp_pkg::ACCESS_CYC - fpp_pkg::CYC_ONE)
            begin
              cfg_data <= dq_f;
              cfg_cclk <= 1'b1;
              cfg_state_q <= fpp_pkg::CFG_CLOCK;
            end
          end
          fpp_pkg::CFG_CLOCK:
          begin
            cfg_cclk <= 1'b0;
            cyc_q <= fpp_pkg::CYC_ZERO;
            cfg_cnt_q <= cfg_cnt_d;
            if (done_f || !init_n_f || cfg_cnt_d == fpp_pkg::CFG_MAX_ADDR) // RULE12
              cfg_state_q <= fpp_pkg::CFG_IDLE;
            else
              cfg_state_q <= fpp_pkg::CFG_READ;
          end
          default:
            cfg_state_q <= fpp_pkg::CFG_IDLE;
        endcase
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence cmd_wr(logic [7:0] code);
    clk_en && host_ok && wr_evt && hit(addr_f, fpp_pkg::OFS_CMD) && din_f == code;
  endsequence

  sequence reset_wr;
    clk_en && wr_evt && hit(addr_f, fpp_pkg::OFS_RESET);
  endsequence

  unlock_lo_a: assert property (cmd_wr(fpp_pkg::CMD_UNLOCK_LO) |=> // RULE1
    flash_addr == 19'h02aaa)
    else $error("unlock command 0x20 did not set address 0x2aaa");
  unlock_hi_a: assert property (cmd_wr(fpp_pkg::CMD_UNLOCK_HI) |=> // RULE2
    flash_addr == 19'h05555)
    else $error("unlock command 0x21 did not set address 0x5555");
  read_strobe_a: assert property (cmd_wr(fpp_pkg::CMD_READ) |=> // RULE3
    !flash_ce_n && !flash_oe_n && flash_we_n && flash_dq_oe_n)
    else $error("read command gave wrong strobes");
  write_strobe_a: assert property (cmd_wr(fpp_pkg::CMD_WRITE) |=> // RULE4
    !flash_ce_n && flash_oe_n && !flash_we_n && !flash_dq_oe_n)
    else $error("write command gave wrong strobes");
  standby_a: assert property (cmd_wr(fpp_pkg::CMD_STANDBY) |=> // RULE5
    flash_ce_n && flash_oe_n && flash_we_n)
    else $error("stand-by command left a strobe low");
  data_drive_a: assert property (clk_en && host_ok && wr_evt // RULE6
    && hit(addr_f, fpp_pkg::OFS_DATA) |=> flash_dq_out == $past(din_f))
    else $error("data write did not reach the flash lines");
  data_read_a: assert property (clk_en && rd_evt && hit(addr_f, fpp_pkg::OFS_DATA) // RULE6
    |=> link_d_out == $past(dq_f) ##1 !link_d_oe_n || link_rd_n)
    else $error("data read did not return the flash lines");
  low_addr_a: assert property (clk_en && host_ok && wr_evt // RULE7
    && hit(addr_f, fpp_pkg::OFS_ADDR_LOW) |=> flash_addr[7:0] == $past(din_f))
    else $error("low address write lost");
  mid_addr_a: assert property (clk_en && host_ok && wr_evt // RULE8
    && hit(addr_f, fpp_pkg::OFS_ADDR_MID) |=> flash_addr[15:8] == $past(din_f))
    else $error("middle address write lost");
  high_read_a: assert property (clk_en && rd_evt && hit(addr_f, fpp_pkg::OFS_ADDR_HIGH) // RULE9
    |=> link_d_out == {5'h00, $past(flash_addr[18:16])})
    else $error("high address readback wrong");
  restart_seq_a: assert property (reset_wr |=> soft_rst_q ##1 // RULE10
    (cfg_state_q == fpp_pkg::CFG_PROG && !fpga_prog_n && flash_ce_n && flash_oe_n))
    else $error("reset write did not restart configuration");
  status_bits_a: assert property (clk_en && rd_evt && hit(addr_f, fpp_pkg::OFS_STATUS) // RULE11
    |=> link_d_out[7:5] == $past({flash_we_n, flash_oe_n, flash_ce_n})
      && link_d_out[2] == $past(fpga_prog_n))
    else $error("status strobe bits do not match the pins");
  max_flag_a: assert property (clk_en && rd_evt && hit(addr_f, fpp_pkg::OFS_STATUS) // RULE12
    |=> link_d_out[4] == ($past(cfg_cnt_q) == 19'h60000))
    else $error("max address flag wrong");
  bad_cmd_a: assert property (clk_en && host_ok && wr_evt && hit(addr_f, fpp_pkg::OFS_CMD) // RULE18
    && !(din_f inside {8'h20, 8'h21, 8'h41, 8'h42, 8'h47})
    |=> $stable(flash_addr) && $stable({flash_ce_n, flash_oe_n, flash_we_n}))
    else $error("undefined command changed address or strobes");
endmodule
`default_nettype wire

// ===== src/fpp_pkg.sv
// constants, field positions and types of the flash program port
// Summary of operation
// [RULE1] command 0x20 loads the flash address outputs with 0x2AAA
// [RULE2] command 0x21 loads the flash address outputs with 0x5555
// [RULE3] command 0x41 sets read strobes: chip and output enable low, write high
// [RULE4] command 0x42 sets write strobes: chip and write enable low, output high
// [RULE5] command 0x47 sets stand-by: all three strobes high
// [RULE6] data register write drives the flash data lines; read returns their level
// [RULE7] low address register holds flash address bits 7:0, read and write
// [RULE8] middle address register holds flash address bits 15:8, write only
// [RULE9] high address register bits 2:0 hold address 18:16; upper bits read zero
// [RULE10] any write to the reset register restarts logic and configures from flash
// [RULE11] status: done, init_n, prog_n, busy, max address, ce_n, oe_n, we_n
// [RULE12] status bit 4 is one when the config counter equals 0x60000
// [RULE13] host polls status until bit 3 clears, success needs bits 0 and 1 set
// [RULE14] host polls flash readiness by read, data, stand-by until bit 6 settles
// [RULE15] host programs a byte with unlock writes, address, framed data write
// [RULE16] host erases with six framed writes at alternating unlock addresses; the bench writes 0x5555 twice in a row, at writes three and four
// [RULE17] host reads a byte: load address, read command, read data, stand-by
// [RULE18] undefined command codes leave address and strobes unchanged
package fpp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SYNC_STAGES = 3;

  // register byte offsets; the link carries bits 7:2 only
  localparam logic [7:0] OFS_RESET = 8'he4;
  localparam logic [7:0] OFS_STATUS = 8'he8;
  localparam logic [7:0] OFS_CMD = 8'hec;
  localparam logic [7:0] OFS_DATA = 8'hf0;
  localparam logic [7:0] OFS_ADDR_LOW = 8'hf4;
  localparam logic [7:0] OFS_ADDR_MID = 8'hf8;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'hfc;
  localparam int unsigned OFS_LSB = 2;

  localparam logic [7:0] CMD_UNLOCK_LO = 8'h20;
  localparam logic [7:0] CMD_UNLOCK_HI = 8'h21;
  localparam logic [7:0] CMD_READ = 8'h41;
  localparam logic [7:0] CMD_WRITE = 8'h42;
  localparam logic [7:0] CMD_STANDBY = 8'h47;

  localparam int unsigned ADDR_W = 19;
  localparam logic [18:0] UNLOCK_ADDR_LO = 19'h02aaa;
  localparam logic [18:0] UNLOCK_ADDR_HI = 19'h05555;
  localparam logic [18:0] CFG_MAX_ADDR = 19'h60000;
  localparam logic [18:0] ADDR_RESET = 19'h00000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // address field positions
  localparam int unsigned ADDR_LOW_LSB = 0;
  localparam int unsigned ADDR_MID_LSB = 8;
  localparam int unsigned ADDR_HIGH_LSB = 16;
  localparam int unsigned ADDR_HIGH_W = 3;

  // status bit positions
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_INIT_N = 1;
  localparam int unsigned ST_PROG_N = 2;
  localparam int unsigned ST_BUSY = 3;
  localparam int unsigned ST_MAX = 4;
  localparam int unsigned ST_CE_N = 5;
  localparam int unsigned ST_OE_N = 6;
  localparam int unsigned ST_WE_N = 7;

  // timing: least times, rounded up to whole cycles; the access count also adds the synchroniser stages
  localparam int unsigned PROG_PULSE_NS = 500;
  localparam int unsigned FLASH_ACCESS_NS = 120;
  localparam int unsigned CYC_W = 5;
  localparam logic [4:0] PROG_PULSE_CYC =
    5'((PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] ACCESS_CYC =
    5'((FLASH_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
  localparam logic [4:0] CYC_ONE = 5'h01;
  localparam logic [4:0] CYC_ZERO = 5'h00;

  typedef enum logic [2:0] {
    CFG_IDLE,
    CFG_PROG,
    CFG_WAIT_INIT,
    CFG_READ,
    CFG_CLOCK
  } fpp_cfg_state_t;
endpackage

// ===== src/fpp_sync.sv
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module fpp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // asynchronous reset
  input wire logic clk_en, // freezes state while low
  input wire logic [W-1:0] d, // asynchronous input
  output logic [W-1:0] q // filtered, synchronous output
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q <= INIT;
    end
    else if (clk_en)
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // per bit: a bit that is still settling keeps its old value
      q <= (s2_q & s3_q) | (q & (s2_q | s3_q));
    end
  end
endmodule
`default_nettype wire

// ===== testbench/fpp_flash_model.sv
// behavioural byte-wide flash and fpga configuration pins
`timescale 1ns/100ps
`default_nettype none
module fpp_flash_model (
  input wire logic ref_clk, // clock
  input wire logic [18:0] flash_addr, // address
  input wire logic [7:0] flash_dq_out, // port data
  input wire logic flash_dq_oe_n, // port drive, low
  input wire logic flash_ce_n, // chip enable
  input wire logic flash_oe_n, // output enable
  input wire logic flash_we_n, // write enable
  output logic [7:0] flash_dq_in, // resolved data lines
  input wire logic fpga_prog_n, // config start
  input wire logic cfg_cclk, // config clock
  output logic fpga_done, // config done
  output logic fpga_init_n // init, low
);
  logic [7:0] mem [logic [18:0]];
  logic [7:0] last_q = 8'h00;
  logic [2:0] seq_q = 3'h0;
  logic [1:0] busy_q = 2'h0;
  logic [3:0] init_q = 4'h0;
  logic [2:0] pulse_q = 3'h0;
  logic tog_q = 1'b0;
  logic we_q = 1'b1;
  logic oe_q = 1'b1;
  logic done_q = 1'b0;
  logic init_n_q = 1'b0;
  logic [26:0] ad;
  assign ad = {flash_addr, flash_dq_in};
  assign fpga_done = done_q;
  assign fpga_init_n = init_n_q;
  // released lines show the inverse of the last driven level, never a stale copy
  always @*
  begin
    if (!flash_dq_oe_n)
      flash_dq_in = flash_dq_out;
    else if (!flash_ce_n && !flash_oe_n && flash_we_n)
      flash_dq_in = (busy_q != 2'h0) ? {1'b0, tog_q, 6'h00} :
        (mem.exists(flash_addr) ? mem[flash_addr] : 8'hff);
    else
      flash_dq_in = ~last_q;
  end
  always @(posedge ref_clk)
  begin
    if (!flash_dq_oe_n || (!flash_ce_n && !flash_oe_n && flash_we_n))
      last_q <= flash_dq_in;
    we_q <= flash_we_n;
    oe_q <= flash_oe_n;
    // busy status toggles bit 6 once per read cycle
    if (flash_oe_n && !oe_q && busy_q != 2'h0)
    begin
      busy_q <= busy_q - 2'h1;
      tog_q <= !tog_q;
    end
    // a byte is taken as write enable returns high
    if (flash_we_n && !we_q)
    begin
      case (seq_q)
        3'h0, 3'h4: seq_q <= (ad == {19'h05555, 8'haa}) ? seq_q + 3'h1 : 3'h0;
        3'h1, 3'h5: seq_q <= (ad == {19'h02aaa, 8'h55}) ? seq_q + 3'h1 : 3'h0;
        3'h2: seq_q <= (ad == {19'h05555, 8'ha0}) ? 3'h3 :
          ((ad == {19'h05555, 8'h80}) ? 3'h4 : 3'h0);
        default: seq_q <= 3'h0;
      endcase
      if (seq_q == 3'h3)
        mem[flash_addr] = flash_dq_in;
      if (seq_q == 3'h6 && ad == {19'h05555, 8'h10})
        mem.delete();
      if (seq_q == 3'h3 || (seq_q == 3'h6 && ad == {19'h05555, 8'h10}))
        busy_q <= 2'h3;
    end
    if (!fpga_prog_n)
    begin
      init_q <= 4'h0;
      pulse_q <= 3'h0;
      init_n_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (init_q != 4'hf)
    begin
      init_q <= init_q + 4'h1;
      init_n_q <= (init_q == 4'he);
    end
    else if (cfg_cclk && pulse_q != 3'h4)
    begin
      pulse_q <= pulse_q + 3'h1;
      done_q <= (pulse_q == 3'h3);
    end
  end
endmodule
`default_nettype wire

// ===== testbench/flash_program_port_tb.sv
// self-checking bench for the flash program port
`timescale 1ns/100ps
`default_nettype none
module flash_program_port_tb;
  logic ref_clk, reset_n, clk_en, link_d_oe_n, link_rd_n, link_wr_n;
  logic [5:0] link_addr;
  logic [7:0] host_d, link_d_in, link_d_out, flash_dq_in, flash_dq_out, cfg_data, rd_q;
  logic [18:0] flash_addr;
  logic flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n;
  logic fpga_done, fpga_init_n, fpga_prog_n, cfg_cclk;
  logic [7:0] cmd_tab [3] = '{8'h41, 8'h42, 8'h47};
  logic [2:0] pin_tab [3] = '{3'b001, 3'b010, 3'b111};
  logic [2:0] st_tab [3] = '{3'b100, 3'b010, 3'b111};
  logic [7:0] bad_tab [3] = '{8'h00, 8'h33, 8'hff};
  logic [7:0] er_a [6] = '{8'h21, 8'h20, 8'h21, 8'h21, 8'h20, 8'h21};
  logic [7:0] er_d [6] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55, 8'h10};
  int error_cnt;
  int num_checks;
  int i;
  assign link_d_in = link_d_oe_n ? host_d : link_d_out;
  fpp_port uut (.ref_clk, .reset_n, .clk_en, .link_addr, .link_d_in, .link_d_out,
    .link_d_oe_n, .link_rd_n, .link_wr_n, .flash_addr, .flash_dq_in, .flash_dq_out,
    .flash_dq_oe_n, .flash_ce_n, .flash_oe_n, .flash_we_n, .fpga_done, .fpga_init_n,
    .fpga_prog_n, .cfg_data, .cfg_cclk);
  fpp_flash_model flash (.ref_clk, .flash_addr, .flash_dq_out, .flash_dq_oe_n,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_in, .fpga_prog_n, .cfg_cclk,
    .fpga_done, .fpga_init_n);
  task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hang();
    chk(19'h00001, 19'h00000);
    complete_run();
  endtask
  // address and data settle four cycles ahead, matching the strobe filter
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    @(posedge ref_clk);
    link_addr <= ofs[7:2];
    host_d <= d;
    repeat (4) @(posedge ref_clk);
    link_wr_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    link_wr_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] ofs);
    int n;
    @(posedge ref_clk);
    link_addr <= ofs[7:2];
    repeat (4) @(posedge ref_clk);
    link_rd_n <= 1'b0;
    for (n = 0; n < 12 && link_d_oe_n !== 1'b0; n++)
      @(posedge ref_clk);
    if (n == 12)
      hang();
    rd_q = link_d_out;
    link_rd_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(fpp_pkg::OFS_CMD, c);
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] d);
    cmd(a);
    cmd(8'h42);
    wr(fpp_pkg::OFS_DATA, d);
    cmd(8'h47);
  endtask
  task automatic set_addr(input logic [18:0] a);
    wr(fpp_pkg::OFS_ADDR_HIGH, {5'h00, a[18:16]});
    wr(fpp_pkg::OFS_ADDR_MID, a[15:8]);
    wr(fpp_pkg::OFS_ADDR_LOW, a[7:0]);
  endtask
  task automatic read_byte(input logic [18:0] a);
    set_addr(a);
    cmd(8'h41);
    rd(fpp_pkg::OFS_DATA);
    cmd(8'h47);
  endtask
  task automatic poll_ready();
    logic prev;
    int n;
    prev = 1'b0;
    set_addr(19'h00000);
    for (n = 0; n < 10; n++)
    begin
      cmd(8'h41);
      rd(fpp_pkg::OFS_DATA);
      cmd(8'h47);
      if (n > 0 && rd_q[6] === prev)
        break;
      prev = rd_q[6];
    end
    if (n == 10)
      hang();
  endtask
  task automatic wait_cfg();
    int n;
    for (n = 0; n < 40; n++)
    begin
      rd(fpp_pkg::OFS_STATUS);
      if (rd_q[3] === 1'b0)
        break;
    end
    if (n == 40)
      hang();
    rd(fpp_pkg::OFS_STATUS);
    chk(19'(rd_q[4:0]), 19'h00007);
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    error_cnt = 0;
    num_checks = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    link_addr = 6'h00;
    host_d = 8'h00;
    link_rd_n = 1'b1;
    link_wr_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_cfg();
    $display("test power-up configuration done");
    wr(fpp_pkg::OFS_ADDR_HIGH, 8'hff);
    wr(fpp_pkg::OFS_ADDR_MID, 8'ha5);
    wr(fpp_pkg::OFS_ADDR_LOW, 8'h3c);
    chk(flash_addr, 19'h7a53c);
    rd(fpp_pkg::OFS_ADDR_HIGH);
    chk(19'(rd_q), 19'h00007);
    rd(fpp_pkg::OFS_ADDR_MID);
    chk(19'(rd_q), 19'h00000);
    rd(fpp_pkg::OFS_ADDR_LOW);
    chk(19'(rd_q), 19'h0003c);
    rd(8'h00);
    chk(19'(rd_q), 19'h00000);
    cmd(8'h21);
    chk(flash_addr, 19'h05555);
    cmd(8'h20);
    chk(flash_addr, 19'h02aaa);
    $display("test address registers done");
    for (i = 0; i < 3; i++)
    begin
      cmd(cmd_tab[i]);
      chk(19'({flash_ce_n, flash_oe_n, flash_we_n}), 19'(pin_tab[i]));
      rd(fpp_pkg::OFS_STATUS);
      chk(19'(rd_q[7:5]), 19'(st_tab[i]));
    end
    // codes outside the set must not disturb address or strobes
    for (i = 0; i < 3; i++)
    begin
      cmd(bad_tab[i]);
      chk({flash_addr[15:0], flash_ce_n, flash_oe_n, flash_we_n}, 19'h15557);
    end
    // an unknown code must also keep a non-stand-by strobe state
    cmd(8'h41);
    cmd(8'h33);
    chk({flash_addr[15:0], flash_ce_n, flash_oe_n, flash_we_n}, 19'h15551);
    $display("test commands done");
    cmd(8'h42);
    wr(fpp_pkg::OFS_DATA, 8'h5a);
    chk(19'({flash_dq_oe_n, flash_dq_out}), 19'h0005a);
    rd(fpp_pkg::OFS_DATA);
    chk(19'(rd_q), 19'h0005a);
    cmd(8'h47);
    frame(8'h21, 8'haa);
    frame(8'h20, 8'h55);
    frame(8'h21, 8'ha0);
    set_addr(19'h12345);
    cmd(8'h42);
    wr(fpp_pkg::OFS_DATA, 8'h3c);
    cmd(8'h47);
    poll_ready();
    read_byte(19'h12345);
    chk(19'(rd_q), 19'h0003c);
    $display("test program byte done");
    for (i = 0; i < 6; i++)
      frame(er_a[i], er_d[i]);
    poll_ready();
    read_byte(19'h12345);
    chk(19'(rd_q), 19'h000ff);
    $display("test erase done");
    wr(fpp_pkg::OFS_RESET, 8'h00);
    chk({flash_addr[15:0], fpga_prog_n, flash_ce_n, flash_we_n}, 19'h00003);
    rd(fpp_pkg::OFS_STATUS);
    chk(19'(rd_q[3]), 19'h00001);
    wait_cfg();
    chk(19'(cfg_data), 19'h000ff);
    $display("test reset write done");
    complete_run();
  end
endmodule
`default_nettype wire
